// file: hdl/rsc_cause_capture.sv
`timescale 1ns/1ns
module rsc_cause_capture
    import rsc_pkg::*;
(
    // Clock and control
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       ce,
    // Capture strobe and sources
    input  wire logic       capture,
    input  wire logic       srcLowVoltage,
    input  wire logic       srcDebug,
    input  wire logic       srcExternal,
    input  wire logic       srcWatchdog,
    input  wire logic       srcIllegalOp,
    input  wire logic       srcClockGen,
    // Captured flags
    output logic [7:0]      flags_q
);

    logic [7:0] flags_d;

    // ==========================================================
    // Next flags for a captured reset
    always_comb begin
        flags_d = FLAGS_CLEAR;
        if (srcLowVoltage) begin
            flags_d[FLAG_POR]  = flags_q[FLAG_POR];
            flags_d[FLAG_LOWV] = 1'b1;
        end else if (srcDebug) begin
            flags_d = FLAGS_CLEAR;
        end else begin
            flags_d[FLAG_EXT]    = srcExternal;
            flags_d[FLAG_WDOG]   = srcWatchdog;
            flags_d[FLAG_ILLEGAL_OPCODE_FLAG]   = srcIllegalOp;
            flags_d[FLAG_CLKGEN] = srcClockGen;
        end
    end

    // ==========================================================
    // Flag register; power-on is this block's own reset
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_q <= FLAGS_POR_VALUE;
        end else if (ce && capture) begin
            flags_q <= flags_d;
        end
    end

endmodule

// file: hdl/rsc_pkg.sv
package rsc_pkg;

    // ==========================================================
    // Register port
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  ADDR_CAUSE      = 8'h00;
    localparam logic [7:0]  ADDR_DBGFORCE   = 8'h01;
    localparam logic [7:0]  ADDR_OPTIONS    = 8'h02;
    localparam logic [7:0]  ADDR_EVSTAT     = 8'h03;
    localparam logic [7:0]  ADDR_EVMASK     = 8'h04;

    // ==========================================================
    // Reset cause flag positions
    localparam int          FLAG_POR        = 7;
    localparam int          FLAG_EXT        = 6;
    localparam int          FLAG_WDOG       = 5;
    localparam int          FLAG_ILLEGAL_OPCODE_FLAG       = 4;
    localparam int          FLAG_ILLEGAL_ADDRESS_FLAG       = 3;
    localparam int          FLAG_CLKGEN     = 2;
    localparam int          FLAG_LOWV       = 1;
    localparam logic [7:0]  FLAGS_POR_VALUE = 8'h82;
    localparam logic [7:0]  FLAGS_CLEAR     = 8'h00;

    // ==========================================================
    // Debugger force register
    localparam int          DBG_FORCE_BIT   = 0;

    // ==========================================================
    // Option register fields
    localparam int          OPT_WDOG_EN     = 0;
    localparam int          OPT_STOP_EN     = 1;
    localparam int          OPT_DEBUG_EN    = 2;
    localparam logic [2:0]  OPTIONS_RESET   = 3'h1;

    // ==========================================================
    // Event status and mask fields
    localparam int          EV_W            = 3;
    localparam int          EV_CAPTURE      = 0;
    localparam int          EV_SERVICE      = 1;
    localparam int          EV_DEBUG        = 2;
    localparam logic [2:0]  EV_RESET        = 3'h0;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS     = 50;
    localparam int          RESET_HOLD_NS     = 400;
    localparam int          RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          HOLD_W            = 4;
    localparam int          WDOG_W            = 16;
    localparam int          WDOG_TIMEOUT_DEF  = 8192;

    // ==========================================================
    // Reset sequencer states
    typedef enum logic {
        RSC_RUN,
        RSC_HOLD
    } rsc_seq_t;

endpackage

// file: hdl/rsc_top.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module rsc_top
    import rsc_pkg::*;
#(
    parameter int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_DEF
) (
    // Clock and control
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] writeData,
    input  wire logic              writeStrobe,
    input  wire logic              readStrobe,
    output logic      [DATA_W-1:0] readData_q,
    // Reset sources
    input  wire logic              lowVoltageReset,
    input  wire logic              extResetN,
    input  wire logic              illegalAddress,
    input  wire logic              clockGenFail,
    // Opcode decoder
    input  wire logic              opcodeStrobe,
    input  wire logic              opcodeUnimplemented,
    input  wire logic              opcodeIsStop,
    input  wire logic              opcodeIsBackground,
    // System side
    output logic                   systemReset_q,
    output logic                   watchdogRestart_q,
    output logic                   watchdogTimeout,
    output logic      [7:0]        resetCauseFlags,
    output logic                   irq
);

    // ==========================================================
    // Declarations
    rsc_seq_t          seq_q;
    logic [HOLD_W-1:0] holdCount_q;
    logic [2:0]        options_q;
    logic              debugForce_q;
    logic [EV_W-1:0]   evStatus_q;
    logic [EV_W-1:0]   evMask_q;
    logic [EV_W-1:0]   evSet;
    logic [7:0]        flags;
    logic              wrCause;
    logic              wrDbg;
    logic              wrOptions;
    logic              wrMask;
    logic              rdEvStatus;
    logic              illegalOpcode;
    logic              srcExternal;
    logic              srcWatchdog;
    logic              anySource;
    logic              capture;
    logic              holdDone;
    logic              holdActive;
    logic              wdogEnable;
    logic [DATA_W-1:0] readMux;

    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYCLES - 1);

    // ==========================================================
    // Register decode
    always_comb begin
        wrCause    = 1'b0;
        wrDbg      = 1'b0;
        wrOptions  = 1'b0;
        wrMask     = 1'b0;
        rdEvStatus = 1'b0;
        unique case (addr)
            ADDR_CAUSE: begin
                wrCause = writeStrobe;
            end
            ADDR_DBGFORCE: begin
                wrDbg = writeStrobe;
            end
            ADDR_OPTIONS: begin
                wrOptions = writeStrobe;
            end
            ADDR_EVSTAT: begin
                rdEvStatus = readStrobe;
            end
            ADDR_EVMASK: begin
                wrMask = writeStrobe;
            end
            default: begin
                // Unmapped: no strobe reaches any register
            end
        endcase
    end

    // ==========================================================
    // Illegal opcode detection
    // Stop and background are legal only while their enables are set
    always_comb begin
        illegalOpcode = 1'b0;
        if (opcodeStrobe) begin
            if (opcodeUnimplemented) begin
                illegalOpcode = 1'b1;
            end
            if (opcodeIsStop && !options_q[OPT_STOP_EN]) begin
                illegalOpcode = 1'b1;
            end
            if (opcodeIsBackground && !options_q[OPT_DEBUG_EN]) begin
                illegalOpcode = 1'b1;
            end
        end
    end

    // ==========================================================
    // Reset source gathering
    assign srcExternal = !extResetN;
    assign wdogEnable  = options_q[OPT_WDOG_EN];
    assign srcWatchdog = watchdogTimeout && wdogEnable;

    assign anySource = lowVoltageReset
                     || srcExternal
                     || srcWatchdog
                     || illegalOpcode
                     || illegalAddress
                     || clockGenFail
                     || debugForce_q;

    // Sources are sampled only on entry; later ones during the hold are not flagged
    assign capture  = (seq_q == RSC_RUN) && anySource;
    assign holdDone = (holdCount_q == HOLD_LAST) && !srcExternal && !lowVoltageReset;
    assign holdActive = (seq_q == RSC_HOLD) && !holdDone;

    // ==========================================================
    // Reset sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            seq_q       <= RSC_RUN;
            holdCount_q <= '0;
        end else if (ce) begin
            unique case (seq_q)
                RSC_RUN: begin
                    holdCount_q <= '0;
                    if (anySource) begin
                        seq_q <= RSC_HOLD;
                    end
                end
                RSC_HOLD: begin
                    if (holdCount_q != HOLD_LAST) begin
                        holdCount_q <= holdCount_q + 1'b1;
                    end
                    if (holdDone) begin
                        seq_q <= RSC_RUN;
                    end
                end
            endcase
        end
    end

    // Held reset toward the rest of the chip
    always_ff @(posedge clk) begin
        if (reset) begin
            systemReset_q <= 1'b1;
        end else if (ce) begin
            systemReset_q <= capture || holdActive;
        end
    end

    // ==========================================================
    // Debugger forced reset
    // One-cycle request; it produces a reset but no flag
    always_ff @(posedge clk) begin
        if (reset) begin
            debugForce_q <= 1'b0;
        end else if (ce) begin
            debugForce_q <= 1'b0;
            if (wrDbg && writeData[DBG_FORCE_BIT]) begin
                debugForce_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Option bits
    // Every captured reset returns them to defaults
    always_ff @(posedge clk) begin
        if (reset) begin
            options_q <= OPTIONS_RESET;
        end else if (ce) begin
            if (capture) begin
                options_q <= OPTIONS_RESET;
            end else if (wrOptions) begin
                options_q <= writeData[2:0];
            end
        end
    end

    // ==========================================================
    // Watchdog service
    // Writing the flag register services the watchdog and sets the service event; the flags are not written
    always_ff @(posedge clk) begin
        if (reset) begin
            watchdogRestart_q <= 1'b0;
        end else if (ce) begin
            watchdogRestart_q <= wrCause || capture;
        end
    end

    rsc_watchdog #(
        .TIMEOUT_CYCLES (WDOG_TIMEOUT_CYCLES)
    ) uWatchdog (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .enable    (wdogEnable),
        .restart   (watchdogRestart_q),
        .timeout_q (watchdogTimeout)
    );

    // ==========================================================
    // Reset cause capture
    rsc_cause_capture uCapture (
        .clk           (clk),
        .reset         (reset),
        .ce            (ce),
        .capture       (capture),
        .srcLowVoltage (lowVoltageReset),
        .srcDebug      (debugForce_q),
        .srcExternal   (srcExternal),
        .srcWatchdog   (srcWatchdog),
        .srcIllegalOp  (illegalOpcode),
        .srcClockGen   (clockGenFail),
        .flags_q       (flags)
    );

    assign resetCauseFlags = {flags[7:1], 1'b0};

    // ==========================================================
    // Event status and mask
    always_comb begin
        evSet             = '0;
        evSet[EV_CAPTURE] = capture;
        evSet[EV_SERVICE] = wrCause;
        evSet[EV_DEBUG]   = debugForce_q;
    end

    // A set in the same cycle as the clearing read wins, so no event is lost
    for (genvar i = 0; i < EV_W; i++) begin : gEvent
        always_ff @(posedge clk) begin
            if (reset) begin
                evStatus_q[i] <= EV_RESET[i];
            end else if (ce) begin
                if (evSet[i]) begin
                    evStatus_q[i] <= 1'b1;
                end else if (rdEvStatus) begin
                    evStatus_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            evMask_q <= EV_RESET;
        end else if (ce && wrMask) begin
            evMask_q <= writeData[EV_W-1:0];
        end
    end

    assign irq = |(evStatus_q & evMask_q);

    // ==========================================================
    // Read data, one cycle after the strobe
    always_comb begin
        readMux = '0;
        unique case (addr)
            ADDR_CAUSE:    readMux = resetCauseFlags;
            ADDR_DBGFORCE: readMux = '0;
            ADDR_OPTIONS:  readMux = {5'h00, options_q};
            ADDR_EVSTAT:   readMux = {5'h00, evStatus_q};
            ADDR_EVMASK:   readMux = {5'h00, evMask_q};
            default:       readMux = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            readData_q <= '0;
        end else if (ce) begin
            if (readStrobe) begin
                readData_q <= readMux;
            end else begin
                readData_q <= '0;
            end
        end
    end

endmodule

// file: hdl/rsc_watchdog.sv
`timescale 1ns/1ns
module rsc_watchdog
    import rsc_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = WDOG_TIMEOUT_DEF
) (
    // Clock and control
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ce,
    // Watchdog control
    input  wire logic enable,
    input  wire logic restart,
    // Timeout event
    output logic      timeout_q
);

    localparam logic [WDOG_W-1:0] LAST = WDOG_W'(TIMEOUT_CYCLES - 1);

    logic [WDOG_W-1:0] count_q;

    // ==========================================================
    // Counter
    // A disabled watchdog never counts, so it can never time out
    always_ff @(posedge clk) begin
        if (reset) begin
            count_q   <= '0;
            timeout_q <= 1'b0;
        end else if (ce) begin
            timeout_q <= 1'b0;
            if (restart || !enable) begin
                count_q <= '0;
            end else if (count_q == LAST) begin
                count_q   <= '0;
                timeout_q <= 1'b1;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

endmodule

// file: testbench/rsc_source_model.sv
`timescale 1ns/1ns
module rsc_source_model (
    // Command from bench
    input wire logic       clk,
    input wire logic [2:0] kind,
    input wire logic       fire,
    // Reset sources
    output logic           lowVoltageReset,
    output logic           extResetN,
    output logic           illegalAddress,
    output logic           clockGenFail,
    output logic           opcodeStrobe,
    output logic           opcodeUnimplemented,
    output logic           opcodeIsStop,
    output logic           opcodeIsBackground
);
    // =====
    // Source pulses
    logic [2:0] left_q = 3'h0;
    logic [2:0] kind_q = 3'h0;
    logic       junk_q = 1'h0;
    logic       act;

    always_ff @(posedge clk) begin
        junk_q <= ~junk_q;
        if (fire) begin
            left_q <= 3'h4;
            kind_q <= kind;
        end else if (act) begin
            left_q <= left_q - 3'h1;
        end
    end

    assign act             = left_q != 3'h0;
    // Reset line has a pull-up, so it idles high
    assign extResetN       = !(act && kind_q == 3'h1);
    assign lowVoltageReset = act && kind_q == 3'h2;
    assign illegalAddress  = act && kind_q == 3'h3;
    assign clockGenFail    = act && kind_q == 3'h4;
    assign opcodeStrobe    = left_q == 3'h4 && kind_q >= 3'h5;
    // Qualifiers toggle when not strobed so stale values are never trusted
    assign opcodeUnimplemented = opcodeStrobe ? kind_q == 3'h5 : junk_q;
    assign opcodeIsStop        = opcodeStrobe ? kind_q == 3'h6 : junk_q;
    assign opcodeIsBackground  = opcodeStrobe ? kind_q == 3'h7 : ~junk_q;
endmodule

// file: testbench/rsc_top_properties.sv
`timescale 1ns/1ns
module rsc_top_properties
    import rsc_pkg::*;
(
    // Clock and register port
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] writeData,
    input wire logic              writeStrobe,
    input wire logic              readStrobe,
    input wire logic [DATA_W-1:0] readData_q,
    // Sources and results
    input wire logic              lowVoltageReset,
    input wire logic              extResetN,
    input wire logic              opcodeStrobe,
    input wire logic              opcodeUnimplemented,
    input wire logic              systemReset_q,
    input wire logic              watchdogRestart_q,
    input wire logic              watchdogTimeout,
    input wire logic [7:0]        resetCauseFlags
);
    // =====
    // Flag register
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_BIT0_ZERO: assert property (resetCauseFlags[0] == 1'h0)
        else $error("reset cause bit zero set");
    AST_POR_VALUE: assert property ($fell(reset) |-> resetCauseFlags == FLAGS_POR_VALUE)
        else $error("power-on flags wrong");
    AST_READ_CAUSE: assert property (ce && readStrobe && addr == ADDR_CAUSE
        |=> readData_q == $past(resetCauseFlags)) else $error("cause read data wrong");
    // Flags may only move at the edge that enters the reset hold
    AST_FLAGS_HOLD: assert property (!$rose(systemReset_q) |-> $stable(resetCauseFlags))
        else $error("flags changed outside a reset");
    AST_KICK: assert property (ce && writeStrobe && addr == ADDR_CAUSE |=> watchdogRestart_q)
        else $error("cause write did not restart watchdog");
    // =====
    // Capture
    AST_LOWV: assert property ($rose(systemReset_q) && $past(lowVoltageReset)
        |-> resetCauseFlags[6:1] == 6'h01 && resetCauseFlags[7] == $past(resetCauseFlags[7]))
        else $error("low-voltage capture wrong");
    AST_EXT: assert property ($rose(systemReset_q)
        |-> resetCauseFlags[FLAG_EXT] == (!$past(extResetN) && !$past(lowVoltageReset)))
        else $error("external flag wrong");
    AST_ILLEGAL_OPCODE_FLAG: assert property ($rose(systemReset_q) && $past(opcodeStrobe) && $past(opcodeUnimplemented)
        && !$past(lowVoltageReset) |-> resetCauseFlags[FLAG_ILLEGAL_OPCODE_FLAG]) else $error("illegal opcode flag missing");
    AST_ILLEGAL_ADDRESS_FLAG: assert property ($rose(systemReset_q) |-> !resetCauseFlags[FLAG_ILLEGAL_ADDRESS_FLAG])
        else $error("illegal address flag set");
    AST_DEBUG: assert property (ce && writeStrobe && addr == ADDR_DBGFORCE && writeData[DBG_FORCE_BIT]
        && !systemReset_q |-> ##2 systemReset_q && resetCauseFlags == FLAGS_CLEAR)
        else $error("debugger reset flags wrong");
    AST_WDOG_RESET: assert property (watchdogTimeout && !systemReset_q |=> systemReset_q)
        else $error("watchdog timeout did not reset");
endmodule

// file: testbench/rsc_top_tb.sv
`timescale 1ns/1ns
module rsc_top_tb
    import rsc_pkg::*;
;
    // =====
    // Signals
    logic       clk = 1'h0, reset = 1'h1, writeStrobe = 1'h0, readStrobe = 1'h0, fire = 1'h0;
    logic [7:0] addr = 8'h00, writeData = 8'h00, readData_q, resetCauseFlags;
    logic [2:0] kind = 3'h0;
    logic       lowV, extN, illegal_address_flag, clkFail, opStb, opUnimp, opStop, opBgnd;
    logic       systemReset_q, watchdogRestart_q, irq;
    int         miscompares = 0, testsRun = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    // Short watchdog keeps runs brief; scenarios kick it inside this span
    rsc_top #(.WDOG_TIMEOUT_CYCLES(200)) u_rsc_top (.clk(clk), .reset(reset), .ce(1'h1), .addr(addr),
        .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData_q(readData_q),
        .lowVoltageReset(lowV), .extResetN(extN), .illegalAddress(illegal_address_flag), .clockGenFail(clkFail),
        .opcodeStrobe(opStb), .opcodeUnimplemented(opUnimp), .opcodeIsStop(opStop),
        .opcodeIsBackground(opBgnd), .systemReset_q(systemReset_q), .watchdogRestart_q(watchdogRestart_q),
        .watchdogTimeout(), .resetCauseFlags(resetCauseFlags), .irq(irq));

    rsc_source_model u_rsc_source_model (.clk(clk), .kind(kind), .fire(fire), .lowVoltageReset(lowV),
        .extResetN(extN), .illegalAddress(illegal_address_flag), .clockGenFail(clkFail), .opcodeStrobe(opStb),
        .opcodeUnimplemented(opUnimp), .opcodeIsStop(opStop), .opcodeIsBackground(opBgnd));

    // =====
    // Helpers
    task automatic final_report();
        if (miscompares == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        writeData <= d;
        writeStrobe <= 1'h1;
        @(posedge clk);
        writeStrobe <= 1'h0;
    endtask

    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        readStrobe <= 1'h1;
        @(posedge clk);
        readStrobe <= 1'h0;
        @(negedge clk);
        d = readData_q;
    endtask

    task automatic wait_sys(logic lvl);
        int n;
        n = 0;
        while (systemReset_q !== lvl && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n >= 500) begin
            check("systemReset_q", {7'h00, lvl}, {7'h00, systemReset_q});
            final_report();
        end
    endtask

    task automatic cause(logic [2:0] k, logic [7:0] opts, logic [7:0] exp, logic hit);
        logic [7:0] d;
        wr(ADDR_OPTIONS, opts);
        @(posedge clk);
        kind <= k;
        fire <= 1'h1;
        @(posedge clk);
        fire <= 1'h0;
        repeat (3) @(negedge clk);
        check("reset entered", {7'h00, hit}, {7'h00, systemReset_q});
        wait_sys(1'h0);
        rd(ADDR_CAUSE, d);
        check("cause flags", exp, d);
    endtask

    // =====
    // Scenarios
    task automatic t_por();
        logic [7:0] d;
        wait_sys(1'h0);
        rd(ADDR_CAUSE, d);
        check("por flags", FLAGS_POR_VALUE, d);
        rd(8'hFF, d);
        check("unmapped read", 8'h00, d);
    endtask

    task automatic t_sources();
        cause(3'h2, 8'h00, FLAGS_POR_VALUE, 1'h1);
        cause(3'h1, 8'h00, 8'h40, 1'h1);
        cause(3'h2, 8'h00, 8'h02, 1'h1);
        cause(3'h4, 8'h00, 8'h04, 1'h1);
        cause(3'h3, 8'h00, 8'h00, 1'h1);
        cause(3'h5, 8'h00, 8'h10, 1'h1);
    endtask

    task automatic t_opcodes();
        cause(3'h6, 8'h00, 8'h10, 1'h1);
        cause(3'h6, 8'h02, 8'h10, 1'h0);
        cause(3'h7, 8'h00, 8'h10, 1'h1);
        cause(3'h7, 8'h04, 8'h10, 1'h0);
    endtask

    task automatic t_kick();
        logic [7:0] d;
        wr(ADDR_OPTIONS, 8'h01);
        repeat (3) begin
            wr(ADDR_CAUSE, 8'hFF);
            @(negedge clk);
            check("watchdog restart", 8'h01, {7'h00, watchdogRestart_q});
            repeat (150) @(posedge clk);
        end
        check("no reset", 8'h00, {7'h00, systemReset_q});
        rd(ADDR_CAUSE, d);
        check("flags after write", 8'h10, d);
    endtask

    task automatic t_watchdog();
        logic [7:0] d;
        wait_sys(1'h1);
        wait_sys(1'h0);
        rd(ADDR_CAUSE, d);
        check("watchdog flags", 8'h20, d);
        wr(ADDR_OPTIONS, 8'h00);
        repeat (300) @(posedge clk);
        check("disabled watchdog", 8'h00, {7'h00, systemReset_q});
        rd(ADDR_CAUSE, d);
        check("flags held", 8'h20, d);
    endtask

    task automatic t_debug();
        logic [7:0] d;
        wr(ADDR_DBGFORCE, 8'h01);
        wait_sys(1'h1);
        wait_sys(1'h0);
        rd(ADDR_CAUSE, d);
        check("debug flags", 8'h00, d);
    endtask

    task automatic t_irq();
        logic [7:0] d;
        wr(ADDR_EVMASK, 8'h07);
        rd(ADDR_EVSTAT, d);
        check("irq cleared", 8'h00, {7'h00, irq});
        wr(ADDR_CAUSE, 8'h00);
        @(negedge clk);
        check("irq raised", 8'h01, {7'h00, irq});
        wr(ADDR_EVMASK, 8'h00);
        @(negedge clk);
        check("irq masked", 8'h00, {7'h00, irq});
        wr(ADDR_EVMASK, 8'h02);
        @(negedge clk);
        check("irq unmasked", 8'h01, {7'h00, irq});
        rd(ADDR_EVSTAT, d);
        check("event status", 8'h02, d);
        check("irq after read", 8'h00, {7'h00, irq});
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        t_por();
        t_sources();
        t_opcodes();
        t_kick();
        t_watchdog();
        t_debug();
        t_irq();
        final_report();
    end
endmodule

bind rsc_top rsc_top_properties u_rsc_top_properties (.clk, .reset, .ce, .addr, .writeData, .writeStrobe,
    .readStrobe, .readData_q, .lowVoltageReset, .extResetN, .opcodeStrobe, .opcodeUnimplemented,
    .systemReset_q, .watchdogRestart_q, .watchdogTimeout, .resetCauseFlags);
